// ---- core/temp_wire_sensor.sv ----
// Sensor end of the single-wire temperature-to-delay link.
// Assumes die_kelvin comes from the thermal_oscillator logic on clk; straps
// and the wire are asynchronous and synchronised here.
// Notes on behaviour
// - After reset wait idle for a trigger
// - Line only pulled low, never driven high
// - Host pulls low, releases, then stays off
// - Conversion timed from trigger falling edge
// - Respond after multiplier times kelvin microseconds
// - Straps and variant choose one of eight
// - Response low lasts five microseconds per kelvin
// - Long external low abandons conversion, ready
// - Self ready 520 ms after trigger edge
// - Host keeps line high before start
// - Host measures edge to response edge
// - Host divides by multiplier, subtracts 273.15
// - Sensors sharing wire use distinct multipliers
// - Pair multipliers within allowed temperature spread
// - Start pulse at least 2.5 us
// - Start pulse no longer than 1 ms
// - Reset threshold 4.6 to 16 ms
// - Ignore low glitches under 500 ns
`timescale 1ns/1ps
`default_nettype none
module temp_wire_sensor #(
  parameter bit HIGH_RANGE   = 1'b0,
  parameter int TICK_CYC     = temp_wire_pkg::TICK_CYC,
  parameter int GLITCH_CYC   = temp_wire_pkg::GLITCH_CYC,
  parameter int RESET_DET_US = temp_wire_pkg::RESET_MIN_US,
  parameter int READY_US     = temp_wire_pkg::READY_US
) (
  input  wire logic                             clk,
  input  wire logic                             rst,
  input  wire logic                             ce,
  input  wire logic                             delay_select_msb,
  input  wire logic                             delay_select_lsb,
  input  wire logic [temp_wire_pkg::TEMP_W-1:0] die_kelvin,
  temp_wire_if.sensor                           bus,
  output logic                                  busy,
  output logic                                  responding
);

  localparam int US_W = temp_wire_pkg::US_W;
  localparam int FW   = $clog2(GLITCH_CYC + 1);
  localparam int TW   = $clog2(TICK_CYC + 1);

  // Synchronisers for the wire and the straps
  logic       line_s1_q;
  logic       line_s2_q;
  logic [1:0] sel_s1_q;
  logic [1:0] sel_s2_q;

  // Glitch filter
  logic [FW-1:0] flt_cnt_q;
  logic          line_low_q;
  logic          raw_low;
  logic          flt_flip;
  logic          line_fall;

  // Microsecond timebase and counters
  logic [TW-1:0]   tick_cnt_q;
  logic            tick;
  logic [US_W-1:0] elapsed_q;
  logic [US_W-1:0] low_us_q;
  logic [US_W-1:0] target_q;
  logic [US_W-1:0] end_q;

  temp_wire_pkg::sensor_state_t state_q;
  temp_wire_pkg::sensor_state_t state_d;
  logic                         drive_q;

  logic [temp_wire_pkg::MULT_W-1:0] mult_w;
  logic [US_W-1:0]                  target_w;
  logic [US_W-1:0]                  low_time_w;
  logic                             ext_reset;
  logic                             ready_due;
  logic                             arm;

  always_ff @(posedge clk) begin
    if (rst) begin
      line_s1_q <= 1'b1;
      line_s2_q <= 1'b1;
      sel_s1_q  <= 2'h0;
      sel_s2_q  <= 2'h0;
    end else if (ce) begin
      line_s1_q <= bus.line;
      line_s2_q <= line_s1_q;
      sel_s1_q  <= {delay_select_msb, delay_select_lsb};
      sel_s2_q  <= sel_s1_q;
    end
  end

  // A level change must persist GLITCH_CYC samples before it is believed
  assign raw_low  = ~line_s2_q;
  assign flt_flip = (raw_low != line_low_q) && (flt_cnt_q == FW'(GLITCH_CYC - 1));

  always_ff @(posedge clk) begin
    if (rst) begin
      flt_cnt_q  <= '0;
      line_low_q <= 1'b0;
    end else if (ce) begin
      if (raw_low == line_low_q || flt_flip) begin
        flt_cnt_q <= '0;
      end else begin
        flt_cnt_q <= flt_cnt_q + FW'(1);
      end
      if (flt_flip) begin
        line_low_q <= raw_low;
      end
    end
  end

  assign line_fall = flt_flip && raw_low;

  // Strap decode, sampled only when a conversion is armed
  assign mult_w     = HIGH_RANGE ? temp_wire_pkg::MULT_HIGH[sel_s2_q]
                                 : temp_wire_pkg::MULT_LOW[sel_s2_q];
  assign target_w   = US_W'(mult_w) * US_W'(die_kelvin);
  assign low_time_w = US_W'(temp_wire_pkg::LOW_TIME_MULT) * US_W'(die_kelvin);

  assign arm       = (state_q == temp_wire_pkg::ST_READY) && line_fall;
  assign tick      = (tick_cnt_q == TW'(TICK_CYC - 1));
  assign ext_reset = (low_us_q >= US_W'(RESET_DET_US));
  assign ready_due = (elapsed_q >= US_W'(READY_US));

  // Timebase restarts at the trigger edge so the delay is edge-aligned
  always_ff @(posedge clk) begin
    if (rst) begin
      tick_cnt_q <= '0;
      elapsed_q  <= '0;
      target_q   <= '0;
      end_q      <= '0;
    end else if (ce) begin
      if (arm || tick) begin
        tick_cnt_q <= '0;
      end else begin
        tick_cnt_q <= tick_cnt_q + TW'(1);
      end
      if (arm) begin
        elapsed_q <= '0;
        target_q  <= target_w;
        end_q     <= target_w + low_time_w;
      end else if (tick && state_q != temp_wire_pkg::ST_READY) begin
        elapsed_q <= elapsed_q + US_W'(1);
      end
    end
  end

  // Our own pull does not count as an external reset pulse
  always_ff @(posedge clk) begin
    if (rst) begin
      low_us_q <= '0;
    end else if (ce) begin
      if (!line_low_q || drive_q) begin
        low_us_q <= '0;
      end else if (tick && !ext_reset) begin
        low_us_q <= low_us_q + US_W'(1);
      end
    end
  end

  always_comb begin
    state_d = state_q;
    case (state_q)
      temp_wire_pkg::ST_READY: begin
        if (line_fall) begin
          state_d = temp_wire_pkg::ST_TRIG;
        end
      end
      temp_wire_pkg::ST_TRIG: begin
        if (ready_due) begin
          state_d = temp_wire_pkg::ST_READY;
        end else if (ext_reset) begin
          state_d = temp_wire_pkg::ST_HELD;
        end else if (!line_low_q) begin
          state_d = temp_wire_pkg::ST_DELAY;
        end
      end
      temp_wire_pkg::ST_DELAY: begin
        if (ready_due) begin
          state_d = temp_wire_pkg::ST_READY;
        end else if (ext_reset) begin
          state_d = temp_wire_pkg::ST_HELD;
        end else if (elapsed_q >= target_q) begin
          state_d = temp_wire_pkg::ST_DRIVE;
        end
      end
      temp_wire_pkg::ST_DRIVE: begin
        if (ready_due) begin
          state_d = temp_wire_pkg::ST_READY;
        end else if (elapsed_q >= end_q) begin
          state_d = temp_wire_pkg::ST_SETTLE;
        end
      end
      temp_wire_pkg::ST_SETTLE: begin
        // Further triggers are ignored until the ready time or a reset
        if (ready_due) begin
          state_d = temp_wire_pkg::ST_READY;
        end else if (ext_reset) begin
          state_d = temp_wire_pkg::ST_HELD;
        end
      end
      temp_wire_pkg::ST_HELD: begin
        // Wait for release so the reset pulse is not seen as a trigger
        if (!line_low_q) begin
          state_d = temp_wire_pkg::ST_READY;
        end
      end
      default: begin
        state_d = temp_wire_pkg::ST_READY;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      state_q <= temp_wire_pkg::ST_READY;
      drive_q <= 1'b0;
    end else if (ce) begin
      state_q <= state_d;
      drive_q <= (state_d == temp_wire_pkg::ST_DRIVE);
    end
  end

  // Open drain: output value is always low, only the enable moves
  assign bus.dev_o  = 1'b0;
  assign bus.dev_oe = drive_q;
  assign busy       = (state_q != temp_wire_pkg::ST_READY);
  assign responding = drive_q;

endmodule // temp_wire_sensor
`default_nettype wire

// ---- core/temp_wire_pkg.sv ----
// Shared constants for the single-wire temperature-to-delay link.
// Assumes a 125 MHz system clock on both ends of the wire.
package temp_wire_pkg;

  localparam int CLK_MHZ        = 125;
  // One microsecond tick, the unit of every long count
  localparam int TICK_CYC       = CLK_MHZ;
  localparam int GLITCH_NS      = 500;
  // Least time: round up
  localparam int GLITCH_CYC     = (GLITCH_NS * CLK_MHZ + 999) / 1000;
  localparam int START_MIN_NS   = 2500;
  localparam int START_MIN_CYC  = (START_MIN_NS * CLK_MHZ + 999) / 1000;
  localparam int START_MAX_US   = 1000;
  localparam int RESET_MIN_US   = 4600;
  localparam int RESET_MAX_US   = 16000;
  localparam int READY_MS       = 520;
  localparam int READY_US       = READY_MS * 1000;
  localparam int SETUP_US       = 10;
  localparam int START_LOW_US   = 100;
  localparam int CENTI          = 100;
  localparam int KELVIN_CENTI   = 27315;

  localparam int US_W           = 20;
  localparam int TEMP_W         = 10;
  localparam int MULT_W         = 10;
  localparam int DIV_W          = 26;

  localparam logic [MULT_W-1:0] LOW_TIME_MULT = 10'h005;
  localparam logic [MULT_W-1:0] MULT_LOW  [4] = '{10'h005, 10'h014, 10'h028, 10'h050};
  localparam logic [MULT_W-1:0] MULT_HIGH [4] = '{10'h0A0, 10'h140, 10'h1E0, 10'h280};

  typedef enum logic [2:0] {
    ST_READY,
    ST_TRIG,
    ST_DELAY,
    ST_DRIVE,
    ST_SETTLE,
    ST_HELD
  } sensor_state_t;

  typedef enum logic [2:0] {
    H_IDLE,
    H_SETUP,
    H_START,
    H_LISTEN,
    H_DIVIDE,
    H_RESET,
    H_RELEASE
  } host_state_t;

endpackage

// ---- core/temp_wire_if.sv ----
// Open-drain wire joining one host and one sensor.
// Assumes an external pull-up: the line is high unless someone pulls low.
`timescale 1ns/1ps
`default_nettype none
interface temp_wire_if;
  logic host_o;
  logic host_oe;
  logic dev_o;
  logic dev_oe;
  wire  line;

  assign line = ~((host_oe & ~host_o) | (dev_oe & ~dev_o));

  modport host (
    input  line,
    output host_o,
    output host_oe
  );
  modport sensor (
    input  line,
    output dev_o,
    output dev_oe
  );
endinterface
`default_nettype wire

// ---- core/temp_wire_host.sv ----
// Host end: issues start or reset pulses and converts the first reply.
// Assumes one user on clk; the wire is asynchronous and synchronised here.
`timescale 1ns/1ps
`default_nettype none
module temp_wire_host #(
  parameter int TICK_CYC      = temp_wire_pkg::TICK_CYC,
  parameter int SETUP_US      = temp_wire_pkg::SETUP_US,
  parameter int START_LOW_US  = temp_wire_pkg::START_LOW_US,
  parameter int RESET_HOLD_US = temp_wire_pkg::RESET_MAX_US + 1,
  parameter int READY_US      = temp_wire_pkg::READY_US
) (
  input  wire logic                                    clk,
  input  wire logic                                    rst,
  input  wire logic                                    ce,
  input  wire logic                                    meas_valid,
  input  wire logic                                    reset_valid,
  input  wire logic [temp_wire_pkg::MULT_W-1:0]        mult,
  output logic                                         cmd_ready,
  output logic                                         result_valid,
  output logic                                         result_timeout,
  output logic [temp_wire_pkg::US_W-1:0]               result_delay_us,
  output logic signed [temp_wire_pkg::DIV_W:0]         result_centi_c,
  temp_wire_if.host                                    bus
);

  localparam int US_W = temp_wire_pkg::US_W;
  localparam int DW   = temp_wire_pkg::DIV_W;
  localparam int TW   = $clog2(TICK_CYC + 1);
  localparam int SW   = $clog2(DW + 1);

  logic                              line_s1_q;
  logic                              line_s2_q;
  logic                              line_prev_q;
  logic [TW-1:0]                     tick_cnt_q;
  logic [US_W-1:0]                   cnt_q;
  logic [temp_wire_pkg::MULT_W-1:0]  mult_q;
  logic [DW-1:0]                     rem_q;
  logic [DW-1:0]                     quo_q;
  logic [SW-1:0]                     step_q;
  temp_wire_pkg::host_state_t        state_q;
  temp_wire_pkg::host_state_t        state_d;

  logic          tick;
  logic          fall;
  logic          cnt_clr;
  logic          div_done;
  logic          timeout;
  logic [DW-1:0] rem_sh;
  logic          rem_ge;

  always_ff @(posedge clk) begin
    if (rst) begin
      line_s1_q   <= 1'b1;
      line_s2_q   <= 1'b1;
      line_prev_q <= 1'b1;
    end else if (ce) begin
      line_s1_q   <= bus.line;
      line_s2_q   <= line_s1_q;
      line_prev_q <= line_s2_q;
    end
  end

  assign fall      = line_prev_q && !line_s2_q;
  assign tick      = (tick_cnt_q == TW'(TICK_CYC - 1));
  assign cmd_ready = (state_q == temp_wire_pkg::H_IDLE);
  assign timeout   = (state_q == temp_wire_pkg::H_LISTEN) && (cnt_q >= US_W'(READY_US));
  assign div_done  = (state_q == temp_wire_pkg::H_DIVIDE) && (step_q == SW'(DW));
  assign rem_sh    = {rem_q[DW-2:0], quo_q[DW-1]};
  assign rem_ge    = (rem_sh >= DW'(mult_q));

  always_comb begin
    state_d = state_q;
    case (state_q)
      temp_wire_pkg::H_IDLE: begin
        if (reset_valid) begin
          state_d = temp_wire_pkg::H_RESET;
        end else if (meas_valid) begin
          state_d = temp_wire_pkg::H_SETUP;
        end
      end
      temp_wire_pkg::H_SETUP: begin
        if (cnt_q >= US_W'(SETUP_US)) begin
          state_d = temp_wire_pkg::H_START;
        end
      end
      temp_wire_pkg::H_START: begin
        if (cnt_q >= US_W'(START_LOW_US)) begin
          state_d = temp_wire_pkg::H_LISTEN;
        end
      end
      temp_wire_pkg::H_LISTEN: begin
        if (fall) begin
          state_d = temp_wire_pkg::H_DIVIDE;
        end else if (timeout) begin
          state_d = temp_wire_pkg::H_IDLE;
        end
      end
      temp_wire_pkg::H_DIVIDE: begin
        if (div_done) begin
          state_d = temp_wire_pkg::H_IDLE;
        end
      end
      temp_wire_pkg::H_RESET: begin
        if (cnt_q >= US_W'(RESET_HOLD_US)) begin
          state_d = temp_wire_pkg::H_RELEASE;
        end
      end
      temp_wire_pkg::H_RELEASE: begin
        if (line_s2_q) begin
          state_d = temp_wire_pkg::H_IDLE;
        end
      end
      default: begin
        state_d = temp_wire_pkg::H_IDLE;
      end
    endcase
  end

  // Setup time only counts while the wire is seen high
  assign cnt_clr = ((state_d != state_q) && (state_d == temp_wire_pkg::H_SETUP
                   || state_d == temp_wire_pkg::H_START
                   || state_d == temp_wire_pkg::H_RESET))
                   || (state_q == temp_wire_pkg::H_SETUP && !line_s2_q);

  always_ff @(posedge clk) begin
    if (rst) begin
      state_q    <= temp_wire_pkg::H_IDLE;
      tick_cnt_q <= '0;
      cnt_q      <= '0;
    end else if (ce) begin
      state_q    <= state_d;
      tick_cnt_q <= (cnt_clr || tick) ? '0 : tick_cnt_q + TW'(1);
      if (cnt_clr) begin
        cnt_q <= '0;
      end else if (tick && !timeout) begin
        cnt_q <= cnt_q + US_W'(1);
      end
    end
  end

  // Restoring divide of delay*100 by the multiplier, one bit a cycle
  always_ff @(posedge clk) begin
    if (rst) begin
      mult_q <= '0;
      rem_q  <= '0;
      quo_q  <= '0;
      step_q <= '0;
    end else if (ce) begin
      if (cmd_ready && meas_valid) begin
        mult_q <= mult;
      end
      if (state_q == temp_wire_pkg::H_LISTEN && fall) begin
        rem_q  <= '0;
        quo_q  <= DW'(cnt_q) * DW'(temp_wire_pkg::CENTI);
        step_q <= '0;
      end else if (state_q == temp_wire_pkg::H_DIVIDE && !div_done) begin
        rem_q  <= rem_ge ? rem_sh - DW'(mult_q) : rem_sh;
        quo_q  <= {quo_q[DW-2:0], rem_ge};
        step_q <= step_q + SW'(1);
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      result_valid    <= 1'b0;
      result_timeout  <= 1'b0;
      result_delay_us <= '0;
      result_centi_c  <= '0;
    end else if (ce) begin
      result_valid <= div_done || timeout;
      if (state_q == temp_wire_pkg::H_LISTEN && fall) begin
        result_delay_us <= cnt_q;
      end
      if (timeout) begin
        result_timeout  <= 1'b1;
        result_delay_us <= cnt_q;
        result_centi_c  <= '0;
      end else if (div_done) begin
        result_timeout <= 1'b0;
        result_centi_c <= $signed({1'b0, quo_q})
                          - (DW+1)'(temp_wire_pkg::KELVIN_CENTI);
      end
    end
  end

  assign bus.host_o  = 1'b0;
  assign bus.host_oe = (state_q == temp_wire_pkg::H_START)
                       || (state_q == temp_wire_pkg::H_RESET);

endmodule // temp_wire_host
`default_nettype wire

// ---- dv/temp_wire_props.sv ----
// Concurrent checks on the wire joining one host and one sensor.
// Assumes both ends run on clk with rst synchronous, active high.
`timescale 1ns/1ps
`default_nettype none
module temp_wire_props #(
  parameter int TICK_CYC      = temp_wire_pkg::TICK_CYC,
  parameter int SETUP_US      = temp_wire_pkg::SETUP_US,
  parameter int START_LOW_US  = temp_wire_pkg::START_LOW_US,
  parameter int RESET_HOLD_US = temp_wire_pkg::RESET_MAX_US + 1
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic host_o,
  input wire logic host_oe,
  input wire logic dev_o,
  input wire logic dev_oe,
  input wire logic line
);
  localparam int START_CYC = START_LOW_US * TICK_CYC;
  localparam int RESET_CYC = RESET_HOLD_US * TICK_CYC;
  localparam int SETUP_CYC = (SETUP_US - 1) * TICK_CYC;
  logic [31:0] low_q;
  logic [31:0] high_q;
  logic        oe_q;
  logic        setup_ok_q;

  default clocking @(posedge clk); endclocking
  default disable iff (rst);

  // Run lengths of host pull and of idle-high line
  always_ff @(posedge clk) begin
    low_q      <= (rst || !host_oe) ? 32'h0 : low_q + 32'h1;
    high_q     <= (rst || !line) ? 32'h0 : high_q + 32'h1;
    oe_q       <= rst ? 1'b0 : host_oe;
    setup_ok_q <= (host_oe && !oe_q) ? (high_q >= 32'(SETUP_CYC)) : setup_ok_q;
  end

  sequence s_start_end;
    $fell(host_oe) && low_q < 32'(RESET_CYC);
  endsequence
  sequence s_reset_end;
    $fell(host_oe) && low_q >= 32'(RESET_CYC);
  endsequence

  property p_dev_low_only;      dev_oe |-> !dev_o;                 endproperty
  property p_host_low_only;     host_oe |-> !host_o;               endproperty
  property p_reset_quiet;
    disable iff (1'b0) rst |=> (!dev_oe && !host_oe);
  endproperty
  property p_reply_after_release; $rose(dev_oe) |-> !host_oe;      endproperty
  property p_start_len;
    s_start_end |-> (low_q >= 32'(START_CYC) && low_q <= 32'(START_CYC + TICK_CYC));
  endproperty
  property p_setup;             s_start_end |-> setup_ok_q;        endproperty
  property p_reply_len;         $rose(dev_oe) |-> dev_oe [*5];     endproperty
  property p_reply_single;      $fell(dev_oe) |-> !dev_oe [*8];    endproperty
  property p_reset_wire_quiet;  s_reset_end |-> !dev_oe [*8];      endproperty

  a_dev_low_only: assert property (p_dev_low_only)
    else $error("sensor drives the wire high");
  a_host_low_only: assert property (p_host_low_only)
    else $error("host drives the wire high");
  a_reset_quiet: assert property (p_reset_quiet)
    else $error("wire pulled during or after reset");
  a_reply_after_release: assert property (p_reply_after_release)
    else $error("sensor replied while host still pulls");
  a_start_len: assert property (p_start_len)
    else $error("start pulse length off");
  a_setup: assert property (p_setup)
    else $error("start pulse without idle high before it");
  a_reply_len: assert property (p_reply_len)
    else $error("reply pulse too short");
  a_reply_single: assert property (p_reply_single)
    else $error("reply pulse repeated");
  a_reset_wire_quiet: assert property (p_reset_wire_quiet)
    else $error("sensor replied right after reset pulse");
endmodule // temp_wire_props
`default_nettype wire

// ---- dv/temp_to_delay_single_wire_bench.sv ----
// Bench joining host and sensor on one wire, plus a second sensor on a
// wire the bench pulls itself. Assumes shortened ticks and timeouts.
`timescale 1ns/1ps
`default_nettype none
module temp_to_delay_single_wire_bench;
  localparam int TICK  = 2;
  localparam int GLT   = 3;
  localparam int RDET  = 50;
  localparam int RDY   = 2000;
  localparam int START = 10;
  localparam int RHOLD = 60;
  localparam int TICK_B = 1;
  localparam int RDY_B  = 12000;
  typedef struct packed {
    logic        to;
    logic [19:0] lo;
    logic [9:0]  mult;
  } note_t;
  logic               clk         = 1'b0;
  logic               rst         = 1'b1;
  logic               meas_valid  = 1'b0;
  logic               reset_valid = 1'b0;
  logic [9:0]         mult        = 10'h005;
  logic [9:0]         kelvin      = 10'h00A;
  logic [1:0]         sel         = 2'h0;
  logic [1:0]         sel_b       = 2'h0;
  logic [31:0]        lfsr        = 32'h0000D408;
  logic               cmd_ready;
  logic               result_valid;
  logic               result_timeout;
  logic [19:0]        result_delay_us;
  logic signed [26:0] result_centi_c;
  logic               busy;
  logic               responding;
  logic               busy_b;
  logic               ce_b        = 1'b1;
  int                 want_c;
  note_t              notes[$];
  note_t              head;
  int                 errors      = 0;
  int                 check_count = 0;

  temp_wire_if w();
  temp_wire_if w_b();
  always #4 clk = ~clk;

  temp_wire_host #(.TICK_CYC(TICK), .START_LOW_US(START), .RESET_HOLD_US(RHOLD),
    .READY_US(RDY)) i_temp_wire_host (.clk(clk), .rst(rst), .ce(1'b1),
    .meas_valid(meas_valid), .reset_valid(reset_valid), .mult(mult),
    .cmd_ready(cmd_ready), .result_valid(result_valid), .result_timeout(result_timeout),
    .result_delay_us(result_delay_us), .result_centi_c(result_centi_c), .bus(w.host));
  temp_wire_sensor #(.TICK_CYC(TICK), .GLITCH_CYC(GLT), .RESET_DET_US(RDET),
    .READY_US(RDY)) i_temp_wire_sensor (.clk(clk), .rst(rst), .ce(1'b1),
    .delay_select_msb(sel[1]), .delay_select_lsb(sel[0]), .die_kelvin(kelvin),
    .bus(w.sensor), .busy(busy), .responding(responding));
  // Second sensor, high range: its wire is pulled by the bench, rules broken on purpose
  // Alone on its wire, so its reply never meets another sensor's
  temp_wire_sensor #(.HIGH_RANGE(1'b1), .TICK_CYC(TICK_B), .GLITCH_CYC(GLT),
    .RESET_DET_US(RDET), .READY_US(RDY_B)) i_temp_wire_sensor_b (.clk(clk), .rst(rst),
    .ce(ce_b),
    .delay_select_msb(sel_b[1]), .delay_select_lsb(sel_b[0]), .die_kelvin(kelvin),
    .bus(w_b.sensor), .busy(busy_b), .responding());
  temp_wire_props #(.TICK_CYC(TICK), .SETUP_US(temp_wire_pkg::SETUP_US),
    .START_LOW_US(START), .RESET_HOLD_US(RHOLD)) i_temp_wire_props (.clk(clk),
    .rst(rst), .host_o(w.host_o), .host_oe(w.host_oe), .dev_o(w.dev_o),
    .dev_oe(w.dev_oe), .line(w.line));

  function automatic logic [31:0] lfsr_next(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction

  task automatic tally(input logic ok, input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (ok !== 1'b1) begin
      errors++;
      $display("wrong value at %0t ns: got %0h expected %0h", $time, got, exp);
    end
  endtask

  task automatic conclude();
    $display("checks %0d errors %0d", check_count, errors);
    if (errors == 0 && check_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  function automatic logic cond(input int k);
    case (k)
      0: return cmd_ready === 1'b1;
      1: return busy === 1'b0;
      2: return responding === 1'b0;
      3: return w_b.dev_oe === 1'b1;
      4: return w_b.dev_oe === 1'b0;
      default: return busy_b === 1'b0;
    endcase
  endfunction

  // Bounded wait; n returns the cycles spent
  task automatic wait_on(input int k, output int n);
    for (n = 0; n < 20000 && !cond(k); n++) @(negedge clk);
    if (n == 20000) begin
      errors++;
      conclude();
    end
  endtask

  task automatic measure(input logic to);
    int n;
    note_t nt;
    nt.to   = to;
    nt.mult = mult;
    nt.lo   = 20'(int'(mult) * int'(kelvin));
    wait_on(0, n);
    notes.push_back(nt);
    meas_valid = 1'b1;
    @(negedge clk);
    meas_valid = 1'b0;
    @(negedge clk);
    wait_on(0, n);
  endtask

  task automatic pull_b(input int cyc);
    w_b.host_oe = 1'b1;
    repeat (cyc) @(negedge clk);
    w_b.host_oe = 1'b0;
  endtask

  task automatic new_temp();
    lfsr   = lfsr_next(lfsr);
    kelvin = 10'(10 + int'(lfsr[2:0]));
  endtask

  always @(negedge clk) begin
    if (result_valid === 1'b1) begin
      head = notes.pop_front();
      tally(result_timeout === head.to, 32'(result_timeout), 32'(head.to));
      if (!head.to) begin
        tally(result_delay_us >= head.lo && result_delay_us <= head.lo + 20'h8,
          32'(result_delay_us), 32'(head.lo));
        want_c = int'(result_delay_us) * temp_wire_pkg::CENTI / int'(head.mult)
                 - temp_wire_pkg::KELVIN_CENTI;
        tally(result_centi_c === 27'(want_c), 32'(result_centi_c), 32'(want_c));
      end else begin
        tally(result_delay_us === 20'(RDY) && result_centi_c === 27'h0,
          32'(result_delay_us), 32'(RDY));
      end
    end
  end

  initial begin
    int n;
    int t;
    int m;
    int i;
    w_b.host_o  = 1'b0;
    w_b.host_oe = 1'b0;
    repeat (20) @(negedge clk);
    rst = 1'b0;
    @(negedge clk);
    tally(busy === 1'b0 && cmd_ready === 1'b1, 32'(busy), 32'h0);
    for (i = 0; i < 4; i++) begin
      new_temp();
      sel  = 2'(i);
      mult = temp_wire_pkg::MULT_LOW[i];
      measure(1'b0);
      wait_on(2, n);
      reset_valid = 1'b1;
      @(negedge clk);
      reset_valid = 1'b0;
      wait_on(0, n);
      wait_on(1, n);
      tally(n < 16, n, 16);
    end
    // Second request finds the sensor still busy, so no reply comes
    measure(1'b0);
    measure(1'b1);
    pull_b(GLT - 1);
    repeat (20) @(negedge clk);
    tally(busy_b === 1'b0, 32'(busy_b), 32'h0);
    // Disabled clock: a full trigger must leave no trace
    ce_b = 1'b0;
    pull_b(20);
    repeat (8) @(negedge clk);
    ce_b = 1'b1;
    repeat (8) @(negedge clk);
    tally(busy_b === 1'b0, 32'(busy_b), 32'h0);
    for (i = 0; i < 4; i++) begin
      new_temp();
      sel_b = 2'(i);
      repeat (4) @(negedge clk);
      m = int'(temp_wire_pkg::MULT_HIGH[i]) * int'(kelvin) * TICK_B;
      // Long trigger: reply must still count from the falling edge
      pull_b(40);
      wait_on(3, n);
      t = 40 + n;
      tally(t >= m && t <= m + 16, t, m);
      wait_on(4, n);
      t += n;
      m = int'(temp_wire_pkg::LOW_TIME_MULT) * int'(kelvin) * TICK_B;
      tally(n >= m - TICK_B && n <= m + TICK_B, n, m);
      wait_on(5, n);
      t += n;
      tally(t >= RDY_B * TICK_B && t <= RDY_B * TICK_B + 16, t, RDY_B * TICK_B);
    end
    pull_b(20);
    repeat (40) @(negedge clk);
    pull_b(RDET * TICK_B + 20);
    wait_on(5, n);
    tally(n < 16, n, 16);
    tally(notes.size() == 0, notes.size(), 0);
    conclude();
  end
endmodule // temp_to_delay_single_wire_bench
`default_nettype wire
